// ### hw/htc_i2c_target.sv
// Notes on behaviour
// - Answer only at seven-bit address 0x40; other addresses are ignored.
// - Direction bit one reads from the device, zero writes to it.
// - 0xE5 starts humidity in hold mode, 0xF5 in polling mode.
// - 0xE3 starts temperature in hold mode, 0xF3 in polling mode.
// - 0xE0 returns temperature kept from last humidity run, no conversion.
// - 0xE6 writes the user register, 0xE7 reads it.
// - 0x51 writes the heater register, 0x11 reads it.
// - 0xFA 0x0F and 0xFC 0xC9 return serial identifier halves.
// - Busy conversion shown by clock stretching or refused reads, per code.
// - Polling mode NACKs read address until done; host retries.
// - Checksum follows low byte only if host acknowledged that byte.
// - Checksum is CRC-8, polynomial x^8+x^5+x^4+1, initial value zero.
// - Serial identifier reads always carry checksum bytes.
// - Register, revision and 0xE0 reads return no checksum.
// - Results are 16 bits, high byte sent first, then low.
// - Humidity low byte ends in binary 10.
// - Temperature low byte ends in binary 00.
// - Humidity conversion also keeps a temperature for later reading.
// - Stop before the repeated start is accepted as well.
`timescale 1ns/10ps
`default_nettype none
`include "htc_map.svh"
module htc_i2c_target #(
   parameter logic [63:0] SERIAL_ID   = 64'h0123_4567_89ab_cdef, // Arbitrary value
   parameter logic [7:0]  FW_REVISION = 8'h5a                    // Arbitrary value
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              ce_i,
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   output logic                   scl_o,
   output logic                   scl_oe_o,
   output logic                   sda_o,
   output logic                   sda_oe_o,
   input  wire htc_pkg::htc_conv_s conv_i,
   output logic                   conv_start_o,
   output logic                   conv_hum_o,
   output logic                   busy_o,
   output logic                   soft_reset_o,
   output logic [7:0]             user_reg_o,
   output logic [7:0]             heater_reg_o
);

   htc_pkg::htc_regs_s q;
   htc_pkg::htc_regs_s n;
   logic               scl_rise;
   logic               scl_fall;
   logic               start_c;
   logic               stop_c;
   logic               load;
   logic [8:0]         byte_v;

   function automatic logic [7:0] crc8(input logic [7:0] c_in, input logic [7:0] d);
      logic [7:0] c;
      logic       fb;
      c = c_in;
      for (int i = 7; i >= 0; i--) begin
         fb = c[7] ^ d[i];
         c  = {c[6:0], 1'b0} ^ (fb ? `HTC_CRC_POLY : 8'h00);
      end
      return c;
   endfunction

   // Response byte at a given index: {is_checksum, byte}
   function automatic logic [8:0] resp_byte(input htc_pkg::htc_regs_s r);
      logic [8:0]  b;
      logic [63:0] sh;
      logic [3:0]  k;
      b  = {1'b0, `HTC_IDLE_BYTE};
      sh = '0;
      k  = '0;
      case (r.op)
         htc_pkg::OP_MEAS, htc_pkg::OP_PREV: begin
            if (r.rd_idx == 4'h0) begin
               b = {1'b0, r.result[15:8]};
            end else if (r.rd_idx == 4'h1) begin
               b = {1'b0, r.result[7:0]};
            end else if (r.rd_idx == 4'h2 && r.op == htc_pkg::OP_MEAS) begin
               b = {1'b1, r.crc};
            end
         end
         htc_pkg::OP_USER: if (r.rd_idx == 4'h0) b = {1'b0, r.user};
         htc_pkg::OP_HEAT: if (r.rd_idx == 4'h0) b = {1'b0, r.heater};
         htc_pkg::OP_FW:   if (r.rd_idx == 4'h0) b = {1'b0, FW_REVISION};
         htc_pkg::OP_SNA: begin
            if (r.rd_idx < 4'h8) begin
               sh = SERIAL_ID << {r.rd_idx[2:1], 3'b000};
               b  = r.rd_idx[0] ? {1'b1, r.crc} : {1'b0, sh[63:56]};
            end
         end
         htc_pkg::OP_SNB: begin
            if (r.rd_idx == 4'h2 || r.rd_idx == 4'h5) begin
               b = {1'b1, r.crc};
            end else if (r.rd_idx < 4'h5) begin
               k  = (r.rd_idx < 4'h2) ? r.rd_idx : r.rd_idx - 4'h1;
               sh = SERIAL_ID << {k[1:0], 3'b000};
               b  = {1'b0, sh[31:24]};
            end
         end
         default: b = {1'b0, `HTC_IDLE_BYTE};
      endcase
      return b;
   endfunction

   assign scl_rise = ce_i && q.sync2.scl && !q.prev.scl;
   assign scl_fall = ce_i && !q.sync2.scl && q.prev.scl;
   assign start_c  = ce_i && q.sync2.scl && q.prev.scl && q.prev.sda && !q.sync2.sda;
   assign stop_c   = ce_i && q.sync2.scl && q.prev.scl && !q.prev.sda && q.sync2.sda;
   assign byte_v   = resp_byte(q);

   always_comb begin
      n            = q;
      load         = 1'b0;
      n.sync1      = {scl_i, sda_i};
      n.sync2      = q.sync1;
      n.prev       = q.sync2;
      n.conv_start = 1'b0;
      n.soft_reset = 1'b0;
      if (q.busy && conv_i.done) begin
         n.busy = 1'b0;
         if (q.meas_hum) begin
            n.result    = {conv_i.hum[15:2], `HTC_HUM_TAIL};
            n.last_temp = {conv_i.temp[15:2], `HTC_TMP_TAIL};
         end else begin
            n.result = {conv_i.temp[15:2], `HTC_TMP_TAIL};
         end
      end
      if (start_c) begin
         n.st     = htc_pkg::S_ADDR;
         n.bitcnt = 4'h0;
         n.sda_oe = 1'b0;
      end else if (stop_c) begin
         n.st     = htc_pkg::S_IDLE;
         n.sda_oe = 1'b0;
         n.scl_oe = 1'b0;
      end else begin
         case (q.st)
            htc_pkg::S_ADDR, htc_pkg::S_WR: begin
               if (scl_rise && q.bitcnt < 4'h8) begin
                  n.shreg  = {q.shreg[6:0], q.sync2.sda};
                  n.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall && q.bitcnt == 4'h8) begin
                  if (q.st == htc_pkg::S_ADDR) begin
                     if (q.shreg[7:1] == `HTC_ADDR &&
                         !(q.shreg[0] && q.busy && !q.hold)) begin
                        n.st     = htc_pkg::S_AACK;
                        n.sda_oe = 1'b1;
                        n.rw     = q.shreg[0];
                        n.rd_idx = 4'h0;
                        n.crc    = `HTC_CRC_INIT;
                        if (!q.shreg[0]) n.nwr = 2'd0;
                     end else begin
                        n.st = htc_pkg::S_IDLE;
                     end
                  end else begin
                     n.st     = htc_pkg::S_WACK;
                     n.sda_oe = 1'b1;
                     if (q.nwr != 2'd3) n.nwr = q.nwr + 2'd1;
                     if (q.nwr == 2'd0) begin
                        n.cmd = q.shreg;
                        n.op  = htc_pkg::OP_NONE;
                        case (q.shreg)
                           `HTC_CMD_HUM_HOLD, `HTC_CMD_HUM_POLL,
                           `HTC_CMD_TMP_HOLD, `HTC_CMD_TMP_POLL: begin
                              n.op         = htc_pkg::OP_MEAS;
                              n.busy       = 1'b1;
                              n.conv_start = 1'b1;
                              n.meas_hum   = (q.shreg == `HTC_CMD_HUM_HOLD) ||
                                             (q.shreg == `HTC_CMD_HUM_POLL);
                              n.hold       = !q.shreg[4];
                           end
                           `HTC_CMD_PREV_TMP: begin
                              n.op     = htc_pkg::OP_PREV;
                              n.result = q.last_temp;
                           end
                           `HTC_CMD_USER_RD: n.op = htc_pkg::OP_USER;
                           `HTC_CMD_HEAT_RD: n.op = htc_pkg::OP_HEAT;
                           `HTC_CMD_RESET: begin
                              n.soft_reset = 1'b1;
                              n.user       = `HTC_USER_RST;
                              n.heater     = `HTC_HEAT_RST;
                           end
                           default: n.op = htc_pkg::OP_NONE;
                        endcase
                     end else if (q.nwr == 2'd1) begin
                        case ({q.cmd, q.shreg})
                           `HTC_CMD_SNA: n.op = htc_pkg::OP_SNA;
                           `HTC_CMD_SNB: n.op = htc_pkg::OP_SNB;
                           `HTC_CMD_FW:  n.op = htc_pkg::OP_FW;
                           default: begin
                              if (q.cmd == `HTC_CMD_USER_WR) n.user = q.shreg;
                              if (q.cmd == `HTC_CMD_HEAT_WR) n.heater = q.shreg;
                           end
                        endcase
                     end
                  end
               end
            end
            htc_pkg::S_AACK: begin
               if (scl_fall) begin
                  n.sda_oe = 1'b0;
                  if (!q.rw) begin
                     n.st     = htc_pkg::S_WR;
                     n.bitcnt = 4'h0;
                  end else if (q.busy) begin
                     n.st     = htc_pkg::S_HOLD;
                     n.scl_oe = 1'b1;
                  end else begin
                     load = 1'b1;
                  end
               end
            end
            htc_pkg::S_HOLD: begin
               if (!q.busy) begin
                  n.scl_oe = 1'b0;
                  load     = 1'b1;
               end
            end
            htc_pkg::S_WACK: begin
               if (scl_fall) begin
                  n.sda_oe = 1'b0;
                  n.st     = htc_pkg::S_WR;
                  n.bitcnt = 4'h0;
               end
            end
            htc_pkg::S_RD: begin
               if (scl_fall) begin
                  if (q.bitcnt == 4'h8) begin
                     n.sda_oe = 1'b0;
                     n.st     = htc_pkg::S_RACK;
                  end else begin
                     n.shreg  = {q.shreg[6:0], 1'b0};
                     n.sda_oe = !q.shreg[6];
                     n.bitcnt = q.bitcnt + 4'h1;
                  end
               end
            end
            htc_pkg::S_RACK: begin
               if (scl_rise) n.host_ack = !q.sync2.sda;
               if (scl_fall) begin
                  if (q.host_ack) load = 1'b1;
                  else n.st = htc_pkg::S_IDLE;
               end
            end
            default: n.st = htc_pkg::S_IDLE;
         endcase
      end
      if (load) begin
         n.st     = htc_pkg::S_RD;
         n.shreg  = byte_v[7:0];
         n.sda_oe = !byte_v[7];
         n.bitcnt = 4'h1;
         n.rd_idx = q.rd_idx + 4'h1;
         if (!byte_v[8]) n.crc = crc8(q.crc, byte_v[7:0]);
      end
      if (!ce_i) n = q;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         q        <= '0;
         q.sync1  <= 2'b11;
         q.sync2  <= 2'b11;
         q.prev   <= 2'b11;
         q.user   <= `HTC_USER_RST;
         q.heater <= `HTC_HEAT_RST;
      end else begin
         q <= n;
      end
   end

   assign scl_o        = 1'b0;
   assign sda_o        = 1'b0;
   assign scl_oe_o     = q.scl_oe;
   assign sda_oe_o     = q.sda_oe;
   assign conv_start_o = q.conv_start;
   assign conv_hum_o   = q.meas_hum;
   assign busy_o       = q.busy;
   assign soft_reset_o = q.soft_reset;
   assign user_reg_o   = q.user;
   assign heater_reg_o = q.heater;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence addr_done_s;
      q.st == htc_pkg::S_ADDR && scl_fall && q.bitcnt == 4'h8 && !start_c && !stop_c;
   endsequence
   sequence wr_cmd_s(logic [7:0] code);
      q.st == htc_pkg::S_WR && scl_fall && q.bitcnt == 4'h8 && q.nwr == 2'd0 &&
         q.shreg == code && !start_c && !stop_c;
   endsequence

   addr_ignore_a: assert property (addr_done_s ##0 q.shreg[7:1] != `HTC_ADDR
      |=> q.st == htc_pkg::S_IDLE && !sda_oe_o) else $error("foreign address acked");
   read_dir_a: assert property (q.st == htc_pkg::S_AACK && scl_fall && q.rw && !start_c
      && !stop_c |=> q.st == htc_pkg::S_HOLD || q.st == htc_pkg::S_RD)
      else $error("read address did not start a read");
   hum_start_a: assert property ((wr_cmd_s(`HTC_CMD_HUM_HOLD) or wr_cmd_s(`HTC_CMD_HUM_POLL))
      |=> conv_start_o && conv_hum_o && busy_o ##1 !conv_start_o)
      else $error("humidity command did not start conversion");
   tmp_start_a: assert property ((wr_cmd_s(`HTC_CMD_TMP_HOLD) or wr_cmd_s(`HTC_CMD_TMP_POLL))
      |=> conv_start_o && !conv_hum_o && busy_o)
      else $error("temperature command did not start conversion");
   prev_tmp_a: assert property (wr_cmd_s(`HTC_CMD_PREV_TMP) ##0 !q.busy
      |=> !conv_start_o && q.result == $past(q.last_temp))
      else $error("stored temperature not returned");
   hold_stretch_a: assert property (q.st == htc_pkg::S_HOLD && q.busy |-> scl_oe_o)
      else $error("clock not held during conversion");
   poll_nack_a: assert property (addr_done_s ##0 (q.shreg == {`HTC_ADDR, 1'b1} && q.busy
      && !q.hold) |=> q.st == htc_pkg::S_IDLE && !sda_oe_o)
      else $error("read address acked while busy");
   nack_end_a: assert property (q.st == htc_pkg::S_RACK && scl_fall && !q.host_ack
      && !start_c && !stop_c |=> q.st == htc_pkg::S_IDLE && !sda_oe_o)
      else $error("transfer continued after host nack");
   crc_init_a: assert property (addr_done_s ##0 (q.shreg == {`HTC_ADDR, 1'b1} && !(q.busy
      && !q.hold)) |=> q.crc == `HTC_CRC_INIT && q.rd_idx == 4'h0)
      else $error("checksum not cleared at read start");
   hum_tail_a: assert property (ce_i && q.busy && conv_i.done && q.meas_hum
      |=> q.result[1:0] == `HTC_HUM_TAIL && q.last_temp[1:0] == `HTC_TMP_TAIL && !busy_o)
      else $error("humidity result tail wrong");
   tmp_tail_a: assert property (ce_i && q.busy && conv_i.done && !q.meas_hum
      |=> q.result[1:0] == `HTC_TMP_TAIL) else $error("temperature result tail wrong");
   stop_idle_a: assert property (stop_c |=> q.st == htc_pkg::S_IDLE && !scl_oe_o)
      else $error("stop not honoured");

endmodule // htc_i2c_target
`default_nettype wire

// ### inc/htc_map.svh
`ifndef HTC_MAP_SVH
`define HTC_MAP_SVH

// Bus address
`define HTC_ADDR        7'h40

// Command codes
`define HTC_CMD_HUM_HOLD  8'he5
`define HTC_CMD_HUM_POLL  8'hf5
`define HTC_CMD_TMP_HOLD  8'he3
`define HTC_CMD_TMP_POLL  8'hf3
`define HTC_CMD_PREV_TMP  8'he0
`define HTC_CMD_RESET     8'hfe
`define HTC_CMD_USER_WR   8'he6
`define HTC_CMD_USER_RD   8'he7
`define HTC_CMD_HEAT_WR   8'h51
`define HTC_CMD_HEAT_RD   8'h11
`define HTC_CMD_SNA       16'hfa0f
`define HTC_CMD_SNB       16'hfcc9
`define HTC_CMD_FW        16'h84b8

// Reset values
`define HTC_USER_RST    8'h3a
`define HTC_HEAT_RST    8'h00

// Result tails and checksum
`define HTC_HUM_TAIL    2'b10
`define HTC_TMP_TAIL    2'b00
`define HTC_CRC_POLY    8'h31
`define HTC_CRC_INIT    8'h00
`define HTC_IDLE_BYTE   8'hff

`endif

// ### inc/htc_pkg.sv
`default_nettype none
package htc_pkg;

   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_AACK, S_WR, S_WACK, S_RD, S_RACK, S_HOLD
   } htc_state_e;

   typedef enum logic [2:0] {
      OP_NONE, OP_MEAS, OP_PREV, OP_USER, OP_HEAT, OP_SNA, OP_SNB, OP_FW
   } htc_op_e;

   typedef struct packed {
      logic        scl;
      logic        sda;
   } htc_pins_s;

   typedef struct packed {
      logic        done;
      logic [15:0] hum;
      logic [15:0] temp;
   } htc_conv_s;

   typedef struct packed {
      htc_pins_s   sync1;
      htc_pins_s   sync2;
      htc_pins_s   prev;
      htc_state_e  st;
      htc_op_e     op;
      logic [3:0]  bitcnt;
      logic [7:0]  shreg;
      logic [7:0]  cmd;
      logic [1:0]  nwr;
      logic        rw;
      logic        host_ack;
      logic        sda_oe;
      logic        scl_oe;
      logic        hold;
      logic        busy;
      logic        meas_hum;
      logic        conv_start;
      logic        soft_reset;
      logic [3:0]  rd_idx;
      logic [7:0]  crc;
      logic [15:0] result;
      logic [15:0] last_temp;
      logic [7:0]  user;
      logic [7:0]  heater;
   } htc_regs_s;

endpackage
`default_nettype wire

// ### verification/htc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module htc_host_model (
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   localparam realtime Q = 31.25;
   logic [7:0] rd_data;
   event       rd_ev;

   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   // Bounded wait while the target stretches the clock
   task automatic wait_high();
      for (int i = 0; i < 2000 && scl_i !== 1'b1; i++) #10;
   endtask

   // Start and repeated start alike, with or without a stop before
   task automatic start();
      sda_o = 1'b1;
      #Q scl_o = 1'b1;
      wait_high();
      #Q sda_o = 1'b0;
      #Q scl_o = 1'b0;
      #Q;
   endtask

   task automatic stop();
      sda_o = 1'b0;
      #Q scl_o = 1'b1;
      wait_high();
      #Q sda_o = 1'b1;
      #(2 * Q);
   endtask

   // One bit: SDA set mid-low, sampled mid-high
   task automatic xfer(input logic b, output logic r);
      sda_o = b;
      #Q scl_o = 1'b1;
      wait_high();
      #Q r = sda_i;
      #Q scl_o = 1'b0;
      #Q;
   endtask

   task automatic wr(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(b[i], r);
      xfer(1'b1, r);
      ack = ~r;
   endtask

   task automatic rd(input logic ack, output logic [7:0] b);
      logic r;
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, r);
         b = {b[6:0], r};
      end
      xfer(~ack, r);
      rd_data = b;
      -> rd_ev;
   endtask
endmodule // htc_host_model
`default_nettype wire

// ### verification/htc_i2c_target_test.sv
`timescale 1ns/10ps
`default_nettype none
module htc_i2c_target_test;
   localparam logic [63:0] SER_ID = 64'h9e37_1b5c_d240_86fa; // Arbitrary value
   localparam logic [7:0]  FW_REV = 8'hc3;                    // Arbitrary value
   logic               ref_clk, rst_b, scl_oe, sda_oe, scl_v, sda_v, h_scl, h_sda;
   logic               conv_start, conv_hum, busy, soft_rst, ack, saw_stretch, saw_srst;
   logic               scl_w, sda_w, ce;
   logic [7:0]         user_reg, heat_reg, d, v, c;
   logic [15:0]        res_h, res_t, stored_t;
   htc_pkg::htc_conv_s conv;
   int                 errors, n_checks;
   logic [7:0]         exp_q[$];
   logic [7:0]         codes[4] = '{8'he5, 8'hf5, 8'he3, 8'hf3};

   // Open-drain wires with pull-ups
   assign scl_w = h_scl & (scl_oe ? scl_v : 1'b1);
   assign sda_w = h_sda & (sda_oe ? sda_v : 1'b1);

   htc_i2c_target #(.SERIAL_ID(SER_ID), .FW_REVISION(FW_REV)) u_dut (
      .ref_clk_i(ref_clk), .rst_b_i(rst_b), .ce_i(ce), .scl_i(scl_w), .sda_i(sda_w),
      .scl_o(scl_v), .scl_oe_o(scl_oe), .sda_o(sda_v), .sda_oe_o(sda_oe), .conv_i(conv),
      .conv_start_o(conv_start), .conv_hum_o(conv_hum), .busy_o(busy),
      .soft_reset_o(soft_rst), .user_reg_o(user_reg), .heater_reg_o(heat_reg));
   htc_host_model u_host (.scl_i(scl_w), .sda_i(sda_w), .scl_o(h_scl), .sda_o(h_sda));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      if (scl_oe === 1'b1) saw_stretch <= 1'b1;
      if (soft_rst === 1'b1) saw_srst <= 1'b1;
   end

   task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk_bit(input string what, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function automatic logic [7:0] crc8(input logic [7:0] cr, input logic [7:0] b);
      logic [7:0] x;
      x = cr ^ b;
      for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h31 : {x[6:0], 1'b0};
      return x;
   endfunction

   // Converter: values drawn at the request, answered after a random delay
   initial forever begin
      @(posedge ref_clk);
      if (conv_start === 1'b1) begin
         res_h = 16'($urandom);
         res_t = 16'($urandom);
         chk_bit("busy with start", 1'b1, busy);
         repeat (400 + $urandom % 64) @(posedge ref_clk);
         #1 conv = '{1'b1, res_h, res_t};
         @(posedge ref_clk);
         #1 conv = '{1'b0, 16'($urandom), 16'($urandom)};
      end
   end

   // Each byte the host reads is matched with the oldest note
   initial forever begin
      @(u_host.rd_ev);
      if (exp_q.size() == 0) begin
         errors++;
         $display("CHECK FAILED read byte expected none seen %h", u_host.rd_data);
      end else chk_byte("read byte", exp_q.pop_front(), u_host.rd_data);
   end

   initial begin
      repeat (60000) @(posedge ref_clk);
      errors++;
      $display("CHECK FAILED watchdog expected end seen hang");
      end_sim();
   end

   task automatic wcmd(input logic [7:0] b0, input logic [7:0] b1, input int n);
      u_host.start();
      u_host.wr(8'h80, ack);
      chk_bit("write addr ack", 1'b1, ack);
      u_host.wr(b0, ack);
      chk_bit("command ack", 1'b1, ack);
      if (n > 1) begin
         u_host.wr(b1, ack);
         chk_bit("second byte ack", 1'b1, ack);
      end
   endtask

   // Read n bytes, acking all but the last
   task automatic rdn(input int n);
      u_host.start();
      u_host.wr(8'h81, ack);
      chk_bit("read addr ack", 1'b1, ack);
      for (int i = 0; i < n; i++) u_host.rd(i < n - 1, d);
      #20;
      chk_bit("released after nack", 1'b0, sda_oe);
      u_host.stop();
   endtask

   task automatic meas(input logic [7:0] code, input logic ack_lo);
      logic [15:0] r;
      saw_stretch = 1'b0;
      wcmd(code, 8'h00, 1);
      chk_bit("humidity run", code[2], conv_hum);
      r = code[2] ? {res_h[15:2], 2'b10} : {res_t[15:2], 2'b00};
      if (code[2]) stored_t = {res_t[15:2], 2'b00};
      exp_q.push_back(r[15:8]);
      exp_q.push_back(r[7:0]);
      if (ack_lo) exp_q.push_back(crc8(crc8(8'h00, r[15:8]), r[7:0]));
      if (code[4]) begin
         u_host.stop();
         u_host.start();
         u_host.wr(8'h81, ack);
         chk_bit("poll nack while busy", 1'b0, ack);
         u_host.stop();
         for (int i = 0; i < 1000 && busy === 1'b1; i++) @(posedge ref_clk);
      end
      rdn(ack_lo ? 3 : 2);
      chk_bit("clock held", ~code[4], saw_stretch);
   endtask

   initial begin
      errors = 0;
      n_checks = 0;
      rst_b = 1'b0;
      conv = '0;
      ce = 1'b1;
      saw_srst = 1'b0;
      void'($urandom(69));
      repeat (20) @(posedge ref_clk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      chk_byte("user reset", 8'h3a, user_reg);
      chk_byte("heater reset", 8'h00, heat_reg);
      u_host.start();
      u_host.wr(8'h82, ack);
      chk_bit("foreign addr", 1'b0, ack);
      u_host.stop();
      $display("test address done");
      foreach (codes[i]) begin
         meas(codes[i], 1'b1);
         meas(codes[i], 1'b0);
      end
      $display("test measure done");
      wcmd(8'he0, 8'h00, 1);
      exp_q.push_back(stored_t[15:8]);
      exp_q.push_back(stored_t[7:0]);
      exp_q.push_back(8'hff);
      rdn(3);
      $display("test stored temperature done");
      for (int k = 0; k < 2; k++) begin
         v = 8'($urandom);
         wcmd(k ? 8'h51 : 8'he6, v, 2);
         u_host.stop();
         chk_byte("register out", v, k ? heat_reg : user_reg);
         exp_q.push_back(v);
         wcmd(k ? 8'h11 : 8'he7, 8'h00, 1);
         rdn(1);
      end
      wcmd(8'hfe, 8'h00, 1);
      u_host.stop();
      chk_bit("soft reset pulse", 1'b1, saw_srst);
      chk_byte("user after reset", 8'h3a, user_reg);
      chk_byte("heater after reset", 8'h00, heat_reg);
      $display("test registers done");
      // Frozen block must neither answer nor store
      @(posedge ref_clk);
      #1 ce = 1'b0;
      u_host.start();
      u_host.wr(8'h80, ack);
      chk_bit("frozen addr ack", 1'b0, ack);
      u_host.wr(8'he6, ack);
      u_host.wr(8'h00, ack);
      u_host.stop();
      chk_byte("frozen user", 8'h3a, user_reg);
      @(posedge ref_clk);
      #1 ce = 1'b1;
      $display("test clock enable done");
      c = 8'h00;
      wcmd(8'hfa, 8'h0f, 2);
      for (int i = 0; i < 4; i++) begin
         v = SER_ID[63 - 8 * i -: 8];
         c = crc8(c, v);
         exp_q.push_back(v);
         exp_q.push_back(c);
      end
      rdn(8);
      c = 8'h00;
      wcmd(8'hfc, 8'hc9, 2);
      for (int i = 0; i < 4; i++) begin
         v = SER_ID[31 - 8 * i -: 8];
         c = crc8(c, v);
         exp_q.push_back(v);
         if (i % 2 == 1) exp_q.push_back(c);
      end
      rdn(6);
      wcmd(8'h84, 8'hb8, 2);
      exp_q.push_back(FW_REV);
      rdn(1);
      $display("test identity done");
      repeat (10) @(posedge ref_clk);
      chk_bit("all reads seen", 1'b1, exp_q.size() == 0);
      end_sim();
   end
endmodule // htc_i2c_target_test
`default_nettype wire
